/* File: hdl/link_regs_pkg.sv */
// constants, field layout and types for the link register slice
// assumes a 32-bit software register port and a byte-wide eeprom fetch port
//
// Summary of operation
// - eeprom access bits only act when the eeprom-present flag is one
// - software sets address-clear; hardware zeroes byte address and clears the bit
// - address clear never loads byte zero into the fetched-byte field
// - fetch-go starts a byte read; hardware clears it when the byte arrives
// - fetched-byte field holds the last byte read by a fetch-go; the boot load of word 28h does not touch it
// - small rom offset resets to zero, loads from eeprom word 28h if fitted
// - small rom offset counts as valid only above 61h
// - reserved bits 30-26, 24 and 15-8 of eeprom register read zero
// - dual-phase seconds and cycles caps always read zero
// - physical response retry cap: four writable bits, reset zero
// - async response retry cap: four writable bits
// - async request retry cap: four writable bits
// - whole retry register reads zero after reset
// - swap new-value register holds data stored on a successful compare; hardware loads the old resource value into it on completion
// - swap expected-value register holds data compared with the resource
// - present flag set on detection; bus info block loaded at reset
// - two-bit target select: manager id, bandwidth, channels high, channels low
// - swap complete flag set on completion, cleared by control write
package link_regs_pkg;

  // -----------------------------------------------------------------
  // register offsets
  // -----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_VERSION = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EEPROM = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RETRY = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SWAP_NEW = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_SWAP_EXP = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SWAP_CTRL = 8'h14;

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int PRESENT_BIT = 24;
  localparam int VER_MAJOR_LSB = 16;
  localparam int EE_CLEAR_BIT = 31;
  localparam int EE_GO_BIT = 25;
  localparam int EE_BYTE_LSB = 16;
  localparam int PHYS_CAP_LSB = 8;
  localparam int RESP_CAP_LSB = 4;
  localparam int REQ_CAP_LSB = 0;
  localparam int SWAP_DONE_BIT = 31;

  // -----------------------------------------------------------------
  // values
  // -----------------------------------------------------------------
  localparam logic [7:0] VER_MAJOR = 8'h01;
  localparam logic [7:0] VER_MINOR = 8'h10;
  localparam logic [7:0] SMALL_ROM_WORD = 8'h28;
  localparam logic [7:0] SMALL_ROM_MIN = 8'h61;
  localparam logic [7:0] SMALL_ROM_RESET = 8'h00;
  localparam logic [3:0] RETRY_CAP_RESET = 4'h0;
  localparam logic [7:0] BYTE_ADDR_RESET = 8'h00;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] RESOURCE_RESET = 32'h0000_0000;

  // swap target resources
  typedef enum logic [1:0] {
    SEL_BUS_MANAGER,
    SEL_BANDWIDTH,
    SEL_CHANNELS_HI,
    SEL_CHANNELS_LO
  } swap_sel_e;

endpackage

/* File: hdl/eeprom_byte_fetch.sv */
// one-byte fetch engine towards an external serial eeprom controller
// assumes a four-phase req/ack handshake; data stable while ack is high
`timescale 1ns/100ps
module eeprom_byte_fetch (
  // clock and synchronised reset
  input wire logic clk,
  input wire logic rst_n,
  // request side
  input wire logic start,
  input wire logic [7:0] addr,
  output logic busy,
  output logic done,
  output logic [7:0] fetched,
  // eeprom side
  output logic ee_req,
  output logic [7:0] ee_addr,
  input wire logic ee_ack,
  input wire logic [7:0] ee_data
);
  import link_regs_pkg::*;

  typedef enum logic [1:0] {F_IDLE, F_REQ, F_DROP} fetch_e;

  fetch_e state_ff, nxt_state;
  logic ack_s1_ff, ack_s2_ff;
  logic [7:0] data_s1_ff, data_s2_ff;
  logic req_ff, nxt_req;
  logic done_ff, nxt_done;
  logic [7:0] addr_ff, nxt_addr;
  logic [7:0] byte_ff, nxt_byte;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
      data_s1_ff <= 8'h00;
      data_s2_ff <= 8'h00;
    end else begin
      ack_s1_ff <= ee_ack;
      ack_s2_ff <= ack_s1_ff;
      data_s1_ff <= ee_data;
      data_s2_ff <= data_s1_ff;
    end
  end

  // ---------------------------------------------------------------
  // handshake sequence
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_req = req_ff;
    nxt_done = 1'b0;
    nxt_addr = addr_ff;
    nxt_byte = byte_ff;
    case (state_ff)
      F_IDLE: begin
        if (start) begin
          nxt_req = 1'b1;
          nxt_addr = addr;
          nxt_state = F_REQ;
        end
      end
      F_REQ: begin
        if (ack_s2_ff) begin
          nxt_byte = data_s2_ff;
          nxt_req = 1'b0;
          nxt_done = 1'b1;
          nxt_state = F_DROP;
        end
      end
      F_DROP: begin
        if (!ack_s2_ff) begin
          nxt_state = F_IDLE;
        end
      end
      default: begin
        nxt_state = F_IDLE;
        nxt_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= F_IDLE;
      req_ff <= 1'b0;
      done_ff <= 1'b0;
      addr_ff <= BYTE_ADDR_RESET;
      byte_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      done_ff <= nxt_done;
      addr_ff <= nxt_addr;
      byte_ff <= nxt_byte;
    end
  end

  assign busy = (state_ff != F_IDLE);
  assign done = done_ff;
  assign fetched = byte_ff;
  assign ee_req = req_ff;
  assign ee_addr = addr_ff;

endmodule

/* File: hdl/swap_unit.sv */
// bus-management resources with an atomic compare-swap
// assumes go is a one-cycle pulse from the register slice
`timescale 1ns/100ps
module swap_unit (
  // clock and synchronised reset
  input wire logic clk,
  input wire logic rst_n,
  // operation
  input wire logic go,
  input wire link_regs_pkg::swap_sel_e sel,
  input wire logic [31:0] new_val,
  input wire logic [31:0] exp_val,
  output logic done,
  output logic [31:0] old_val
);
  import link_regs_pkg::*;

  logic [31:0] res_ff [4];
  logic [31:0] nxt_res [4];
  logic done_ff, nxt_done;
  logic [31:0] old_ff, nxt_old;

  // ---------------------------------------------------------------
  // compare and conditional store
  // ---------------------------------------------------------------
  always_comb begin
    nxt_res = res_ff;
    nxt_done = 1'b0;
    nxt_old = old_ff;
    if (go) begin
      nxt_old = res_ff[sel];
      nxt_done = 1'b1;
      if (res_ff[sel] == exp_val) begin
        nxt_res[sel] = new_val;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_ff <= '{default: RESOURCE_RESET};
      done_ff <= 1'b0;
      old_ff <= WORD_RESET;
    end else begin
      res_ff <= nxt_res;
      done_ff <= nxt_done;
      old_ff <= nxt_old;
    end
  end

  assign done = done_ff;
  assign old_val = old_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_swap_guard;
    @(posedge clk) disable iff (!rst_n)
    go && (res_ff[sel] != exp_val) |=> res_ff[$past(sel)] == $past(res_ff[sel]);
  endproperty
  a_swap_guard: assert property (p_swap_guard) else $error("resource changed on mismatch");

endmodule

/* File: hdl/link_eeprom_retry_csr_regs.sv */
// register slice: eeprom byte access, transmit retry caps, compare-swap
// assumes a single-cycle strobe register port and an eeprom fetch handshake
`timescale 1ns/100ps
module link_eeprom_retry_csr_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [link_regs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // eeprom controller pins
  input wire logic ee_present_pin,
  output logic ee_req,
  output logic [7:0] ee_addr,
  input wire logic ee_ack,
  input wire logic [7:0] ee_data,
  // status and settings to the rest of the link
  output logic eeprom_present_flag,
  output logic bus_info_loaded,
  output logic small_rom_valid,
  output logic [3:0] physical_response_retry_cap,
  output logic [3:0] async_response_retry_cap,
  output logic [3:0] async_request_retry_cap
);
  import link_regs_pkg::*;

  typedef enum logic [2:0] {
    B_SETTLE, B_STRAP_WAIT, B_SAMPLE, B_ROM_GO, B_ROM_WAIT, B_RUN
  } boot_e;

  logic rst_s1_ff, rst_sync_n;
  logic pres_s1_ff, pres_s2_ff;
  boot_e boot_ff, nxt_boot;
  logic present_ff, nxt_present;
  logic loaded_ff, nxt_loaded;
  logic clear_ff, nxt_clear;
  logic go_ff, nxt_go;
  logic [7:0] byte_addr_ff, nxt_byte_addr;
  logic [7:0] fetched_byte_ff, nxt_fetched_byte;
  logic [7:0] small_rom_ff, nxt_small_rom;
  logic rom_valid_ff, nxt_rom_valid;
  logic [3:0] phys_cap_ff, nxt_phys_cap;
  logic [3:0] resp_cap_ff, nxt_resp_cap;
  logic [3:0] req_cap_ff, nxt_req_cap;
  logic [31:0] swap_new_ff, nxt_swap_new;
  logic [31:0] swap_exp_ff, nxt_swap_exp;
  swap_sel_e swap_sel_ff, nxt_swap_sel;
  logic swap_done_ff, nxt_swap_done;
  logic [31:0] rdata_ff, nxt_rdata;
  logic fetch_start, fetch_busy, fetch_done;
  logic [7:0] fetch_addr, fetch_byte;
  logic swap_go, swap_fin;
  logic [31:0] swap_old;
  logic wr_eeprom, wr_retry, wr_new, wr_exp, wr_ctrl;

  // ---------------------------------------------------------------
  // reset release and strap synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_sync_n <= rst_s1_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pres_s1_ff <= 1'b0;
      pres_s2_ff <= 1'b0;
    end else begin
      pres_s1_ff <= ee_present_pin;
      pres_s2_ff <= pres_s1_ff;
    end
  end

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  assign wr_eeprom = reg_wr && (reg_addr == OFS_EEPROM);
  assign wr_retry = reg_wr && (reg_addr == OFS_RETRY);
  assign wr_new = reg_wr && (reg_addr == OFS_SWAP_NEW);
  assign wr_exp = reg_wr && (reg_addr == OFS_SWAP_EXP);
  assign wr_ctrl = reg_wr && (reg_addr == OFS_SWAP_CTRL);

  // ---------------------------------------------------------------
  // boot load and eeprom byte access
  // ---------------------------------------------------------------
  // fetcher shared by boot load and software fetches
  assign fetch_start = (boot_ff == B_ROM_GO) ||
                       ((boot_ff == B_RUN) && go_ff && !fetch_busy && !fetch_done);
  assign fetch_addr = (boot_ff == B_RUN) ? byte_addr_ff : SMALL_ROM_WORD;

  always_comb begin
    nxt_boot = boot_ff;
    nxt_present = present_ff;
    nxt_loaded = loaded_ff;
    nxt_clear = clear_ff;
    nxt_go = go_ff;
    nxt_byte_addr = byte_addr_ff;
    nxt_fetched_byte = fetched_byte_ff;
    nxt_small_rom = small_rom_ff;
    nxt_rom_valid = (small_rom_ff > SMALL_ROM_MIN);
    case (boot_ff)
      // strap passes both sync flops before it is sampled
      B_SETTLE: nxt_boot = B_STRAP_WAIT;
      B_STRAP_WAIT: nxt_boot = B_SAMPLE;
      B_SAMPLE: begin
        nxt_present = pres_s2_ff;
        nxt_boot = pres_s2_ff ? B_ROM_GO : B_RUN;
      end
      B_ROM_GO: nxt_boot = B_ROM_WAIT;
      B_ROM_WAIT: begin
        if (fetch_done) begin
          nxt_small_rom = fetch_byte;
          nxt_loaded = 1'b1;
          nxt_boot = B_RUN;
        end
      end
      B_RUN: begin
        if (clear_ff) begin
          nxt_byte_addr = BYTE_ADDR_RESET;
          nxt_clear = 1'b0;
        end else if (fetch_done) begin
          nxt_byte_addr = byte_addr_ff + 8'h01;
        end
        if (fetch_done) begin
          nxt_go = 1'b0;
          nxt_fetched_byte = fetch_byte;
        end
        // set bits only with eeprom present
        if (wr_eeprom && present_ff) begin
          if (reg_wdata[EE_CLEAR_BIT]) begin
            nxt_clear = 1'b1;
          end
          if (reg_wdata[EE_GO_BIT]) begin
            nxt_go = 1'b1;
          end
        end
      end
      default: nxt_boot = B_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      boot_ff <= B_SETTLE;
      present_ff <= 1'b0;
      loaded_ff <= 1'b0;
      clear_ff <= 1'b0;
      go_ff <= 1'b0;
      byte_addr_ff <= BYTE_ADDR_RESET;
      fetched_byte_ff <= 8'h00;
      small_rom_ff <= SMALL_ROM_RESET;
      rom_valid_ff <= 1'b0;
    end else begin
      boot_ff <= nxt_boot;
      present_ff <= nxt_present;
      loaded_ff <= nxt_loaded;
      clear_ff <= nxt_clear;
      go_ff <= nxt_go;
      byte_addr_ff <= nxt_byte_addr;
      fetched_byte_ff <= nxt_fetched_byte;
      small_rom_ff <= nxt_small_rom;
      rom_valid_ff <= nxt_rom_valid;
    end
  end

  eeprom_byte_fetch u_fetch (
    .clk(clk),
    .rst_n(rst_sync_n),
    .start(fetch_start),
    .addr(fetch_addr),
    .busy(fetch_busy),
    .done(fetch_done),
    .fetched(fetch_byte),
    .ee_req(ee_req),
    .ee_addr(ee_addr),
    .ee_ack(ee_ack),
    .ee_data(ee_data)
  );

  // ---------------------------------------------------------------
  // retry caps and compare-swap operands
  // ---------------------------------------------------------------
  assign swap_go = wr_ctrl;

  always_comb begin
    nxt_phys_cap = phys_cap_ff;
    nxt_resp_cap = resp_cap_ff;
    nxt_req_cap = req_cap_ff;
    nxt_swap_new = swap_new_ff;
    nxt_swap_exp = swap_exp_ff;
    nxt_swap_sel = swap_sel_ff;
    nxt_swap_done = swap_done_ff;
    if (wr_retry) begin
      nxt_phys_cap = reg_wdata[PHYS_CAP_LSB +: 4];
      nxt_resp_cap = reg_wdata[RESP_CAP_LSB +: 4];
      nxt_req_cap = reg_wdata[REQ_CAP_LSB +: 4];
    end
    if (wr_new) begin
      nxt_swap_new = reg_wdata;
    end
    if (wr_exp) begin
      nxt_swap_exp = reg_wdata;
    end
    if (wr_ctrl) begin
      nxt_swap_sel = swap_sel_e'(reg_wdata[1:0]);
      nxt_swap_done = 1'b0;
    end
    if (swap_fin) begin
      nxt_swap_done = 1'b1;
      nxt_swap_new = swap_old;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phys_cap_ff <= RETRY_CAP_RESET;
      resp_cap_ff <= RETRY_CAP_RESET;
      req_cap_ff <= RETRY_CAP_RESET;
      swap_new_ff <= WORD_RESET;
      swap_exp_ff <= WORD_RESET;
      swap_sel_ff <= SEL_BUS_MANAGER;
      swap_done_ff <= 1'b1;
    end else begin
      phys_cap_ff <= nxt_phys_cap;
      resp_cap_ff <= nxt_resp_cap;
      req_cap_ff <= nxt_req_cap;
      swap_new_ff <= nxt_swap_new;
      swap_exp_ff <= nxt_swap_exp;
      swap_sel_ff <= nxt_swap_sel;
      swap_done_ff <= nxt_swap_done;
    end
  end

  swap_unit u_swap (
    .clk(clk),
    .rst_n(rst_sync_n),
    .go(swap_go),
    .sel(swap_sel_e'(reg_wdata[1:0])),
    .new_val(swap_new_ff),
    .exp_val(swap_exp_ff),
    .done(swap_fin),
    .old_val(swap_old)
  );

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rdata = WORD_RESET;
    if (reg_rd) begin
      case (reg_addr)
        OFS_VERSION: begin
          nxt_rdata[VER_MAJOR_LSB +: 8] = VER_MAJOR;
          nxt_rdata[7:0] = VER_MINOR;
          nxt_rdata[PRESENT_BIT] = present_ff;
        end
        OFS_EEPROM: begin
          nxt_rdata[EE_CLEAR_BIT] = clear_ff;
          nxt_rdata[EE_GO_BIT] = go_ff;
          nxt_rdata[EE_BYTE_LSB +: 8] = fetched_byte_ff;
          nxt_rdata[7:0] = small_rom_ff;
        end
        OFS_RETRY: begin
          nxt_rdata[PHYS_CAP_LSB +: 4] = phys_cap_ff;
          nxt_rdata[RESP_CAP_LSB +: 4] = resp_cap_ff;
          nxt_rdata[REQ_CAP_LSB +: 4] = req_cap_ff;
        end
        OFS_SWAP_NEW: nxt_rdata = swap_new_ff;
        OFS_SWAP_EXP: nxt_rdata = swap_exp_ff;
        OFS_SWAP_CTRL: begin
          nxt_rdata[SWAP_DONE_BIT] = swap_done_ff;
          nxt_rdata[1:0] = swap_sel_ff;
        end
        default: nxt_rdata = WORD_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata_ff <= WORD_RESET;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // outputs straight from flops
  assign reg_rdata = rdata_ff;
  assign eeprom_present_flag = present_ff;
  assign bus_info_loaded = loaded_ff;
  assign small_rom_valid = rom_valid_ff;
  assign physical_response_retry_cap = phys_cap_ff;
  assign async_response_retry_cap = resp_cap_ff;
  assign async_request_retry_cap = req_cap_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  sequence s_ctrl_write;
    reg_wr && (reg_addr == OFS_SWAP_CTRL);
  endsequence
  sequence s_done_low_then_high;
    !swap_done_ff ##1 swap_done_ff;
  endsequence

  property p_absent_no_go;
    !present_ff && !go_ff |=> !go_ff;
  endproperty
  a_absent_no_go: assert property (p_absent_no_go) else $error("go set without eeprom");
  property p_clear_done;
    clear_ff && (boot_ff == B_RUN) && !(wr_eeprom && reg_wdata[EE_CLEAR_BIT])
      |=> !clear_ff && (byte_addr_ff == 8'h00);
  endproperty
  a_clear_done: assert property (p_clear_done) else $error("address clear incomplete");
  property p_clear_no_load;
    clear_ff && !fetch_done |=> $stable(fetched_byte_ff);
  endproperty
  a_clear_no_load: assert property (p_clear_no_load) else $error("byte loaded on clear");
  property p_go_clears;
    (boot_ff == B_RUN) && fetch_done && !wr_eeprom |=> !go_ff;
  endproperty
  a_go_clears: assert property (p_go_clears) else $error("go not cleared");
  property p_byte_kept;
    (boot_ff == B_RUN) && fetch_done |=> fetched_byte_ff == $past(fetch_byte);
  endproperty
  a_byte_kept: assert property (p_byte_kept) else $error("fetched byte lost");
  property p_rom_load;
    (boot_ff == B_ROM_WAIT) && fetch_done |=> small_rom_ff == $past(fetch_byte) ##1 loaded_ff;
  endproperty
  a_rom_load: assert property (p_rom_load) else $error("small rom not loaded");
  property p_rom_valid;
    rom_valid_ff |-> $past(small_rom_ff) > SMALL_ROM_MIN;
  endproperty
  a_rom_valid: assert property (p_rom_valid) else $error("small rom valid too low");
  property p_ee_reserved;
    reg_rd && (reg_addr == OFS_EEPROM)
      |=> (reg_rdata[30:26] == 5'h0) && !reg_rdata[24] && (reg_rdata[15:8] == 8'h00);
  endproperty
  a_ee_reserved: assert property (p_ee_reserved) else $error("reserved bits nonzero");
  property p_retry_upper;
    reg_rd && (reg_addr == OFS_RETRY) |=> reg_rdata[31:12] == 20'h0_0000;
  endproperty
  a_retry_upper: assert property (p_retry_upper) else $error("dual-phase caps nonzero");
  property p_caps_hold;
    !wr_retry |=> $stable(phys_cap_ff) && $stable(resp_cap_ff) && $stable(req_cap_ff);
  endproperty
  a_caps_hold: assert property (p_caps_hold) else $error("retry caps moved");
  property p_swap_flag;
    !s_ctrl_write ##1 s_ctrl_write ##1 !s_ctrl_write |-> s_done_low_then_high;
  endproperty
  a_swap_flag: assert property (p_swap_flag) else $error("swap flag sequence wrong");

endmodule

/* File: bench/eeprom_model.sv */
// behavioural serial eeprom behind a four-phase byte handshake
// assumes request and address hold until ack is seen
`timescale 1ns/100ps
module eeprom_model (
  // clock and answer delay
  input wire logic clk,
  input wire logic [3:0] lag,
  // fetch handshake
  input wire logic ee_req,
  input wire logic [7:0] ee_addr,
  output logic ee_ack,
  output logic [7:0] ee_data
);
  int wait_n = 0;

  // idle values at time zero
  initial begin
    ee_ack = 1'b0;
    ee_data = 8'ha5;
  end

  // byte n answers n xor 5ah
  always @(posedge clk) begin
    if (ee_req === 1'b1 && ee_ack === 1'b0) begin
      if (wait_n >= lag) begin
        ee_ack <= 1'b1;
        ee_data <= ee_addr ^ 8'h5a;
        wait_n <= 0;
      end else begin
        wait_n <= wait_n + 1;
      end
    end else if (ee_req === 1'b0 && ee_ack === 1'b1) begin
      ee_ack <= 1'b0;
      ee_data <= ~ee_data; // stale data not left on the bus
    end
  end
endmodule

/* File: bench/tb.sv */
// self-checking bench for the link register slice
// assumes the eeprom model answers byte n with n xor 5ah
`timescale 1ns/100ps
`define CHK(nm, e, s) begin comparisons++; \
  if ((s) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", nm, e, s); end end
module tb;
  import link_regs_pkg::*;
  logic clk, reg_wr, reg_rd, ee_req, ee_ack, flag, loaded, rom_ok;
  logic rst_n, strap;
  logic [7:0] reg_addr, ee_addr, ee_data, keep;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [3:0] cap_ph, cap_rs, cap_rq, lag;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  link_eeprom_retry_csr_regs u_link_eeprom_retry_csr_regs (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ee_present_pin(strap), .ee_req(ee_req), .ee_addr(ee_addr),
    .ee_ack(ee_ack), .ee_data(ee_data), .eeprom_present_flag(flag),
    .bus_info_loaded(loaded), .small_rom_valid(rom_ok),
    .physical_response_retry_cap(cap_ph), .async_response_retry_cap(cap_rs),
    .async_request_retry_cap(cap_rq));
  eeprom_model u_eeprom_model (.clk(clk), .lag(lag), .ee_req(ee_req),
    .ee_addr(ee_addr), .ee_ack(ee_ack), .ee_data(ee_data));

  // -----------------------------------------------------------------
  // register port tasks
  // -----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdr(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rd = reg_rdata;
    @(posedge clk);
  endtask

  // waits for a self-clearing bit of 04h
  task automatic poll(input int b);
    for (int i = 0; i < 40; i++) begin
      rdr(OFS_EEPROM);
      if (rd[b] === 1'b0) break;
    end
    `CHK("self clear", 1'b0, rd[b])
  endtask

  task automatic end_of_test;
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_boot;
    for (int i = 0; i < 200 && loaded !== 1'b1; i++) @(posedge clk);
    `CHK("loaded", 1'b1, loaded)
    `CHK("present", 1'b1, flag)
    rdr(OFS_VERSION);
    `CHK("ver bit", 1'b1, rd[PRESENT_BIT])
    rdr(OFS_EEPROM);
    `CHK("rom ofs", 8'h72, rd[7:0])
    `CHK("ee rsvd", WORD_RESET, rd & 32'h7d00_ff00)
    `CHK("rom ok", 1'b1, rom_ok)
    rdr(OFS_RETRY);
    `CHK("retry rst", WORD_RESET, rd)
  endtask

  task automatic t_retry;
    wr(OFS_RETRY, 32'hffff_ffff);
    rdr(OFS_RETRY);
    `CHK("retry rd", 32'h0000_0fff, rd)
    wr(OFS_RETRY, 32'h0000_0321);
    `CHK("phys cap", 4'h3, cap_ph)
    `CHK("resp cap", 4'h2, cap_rs)
    `CHK("req cap", 4'h1, cap_rq)
  endtask

  // address clear, then two fetches, prompt and slow
  task automatic t_fetch;
    rdr(OFS_EEPROM);
    keep = rd[23:16];
    wr(OFS_EEPROM, 32'h8000_0000);
    poll(EE_CLEAR_BIT);
    `CHK("kept byte", keep, rd[23:16])
    for (int i = 0; i < 2; i++) begin
      lag <= 4'(i * 5);
      wr(OFS_EEPROM, 32'h0200_0000);
      poll(EE_GO_BIT);
      `CHK("byte", 8'(i) ^ 8'h5a, rd[23:16])
      `CHK("ee rsvd", WORD_RESET, rd & 32'h7d00_ff00)
    end
  endtask

  // a matching swap then a failing one on each resource
  task automatic t_swap;
    for (int s = 0; s < 4; s++) begin
      wr(OFS_SWAP_NEW, 32'(s + 1));
      wr(OFS_SWAP_EXP, WORD_RESET);
      wr(OFS_SWAP_CTRL, 32'(s));
      rdr(OFS_SWAP_CTRL);
      `CHK("done", 32'h8000_0000 | 32'(s), rd)
      rdr(OFS_SWAP_NEW);
      `CHK("old", WORD_RESET, rd)
      wr(OFS_SWAP_NEW, 32'h0000_0009);
      wr(OFS_SWAP_EXP, 32'h0000_0005);
      rdr(OFS_SWAP_NEW);
      `CHK("new val", 32'h0000_0009, rd)
      rdr(OFS_SWAP_EXP);
      `CHK("exp val", 32'h0000_0005, rd)
      wr(OFS_SWAP_CTRL, 32'(s));
      rdr(OFS_SWAP_NEW);
      `CHK("no swap", 32'(s + 1), rd)
      wr(OFS_SWAP_EXP, 32'(s + 1));
      wr(OFS_SWAP_CTRL, 32'(s));
      rdr(OFS_SWAP_NEW);
      `CHK("kept res", 32'(s + 1), rd)
    end
    wr(8'h40, 32'hffff_ffff);
    rdr(8'h40);
    `CHK("unmapped", WORD_RESET, rd)
  endtask

  // mid-run reset with no eeprom fitted
  task automatic t_absent;
    strap <= 1'b0;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge clk);
    `CHK("absent", 1'b0, flag)
    `CHK("no load", 1'b0, loaded)
    `CHK("rst cap", 4'h0, cap_ph)
    `CHK("rom not ok", 1'b0, rom_ok)
    rdr(OFS_VERSION);
    `CHK("ver bit off", 1'b0, rd[PRESENT_BIT])
    wr(OFS_EEPROM, 32'h8200_0000);
    rdr(OFS_EEPROM);
    `CHK("ee idle", WORD_RESET, rd)
    `CHK("no req", 1'b0, ee_req)
    rdr(OFS_SWAP_CTRL);
    `CHK("done rst", 32'h8000_0000, rd)
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    strap = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = WORD_RESET;
    lag = 4'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_boot;
    t_retry;
    t_fetch;
    t_swap;
    t_absent;
    end_of_test;
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test;
    end
  end
endmodule
